// ---- hdl/zero_cross_event_logic.sv ----
// Digital side of a zero-cross detector with an Avalon-MM register slave.
// Assumes sink_active comes from the asynchronous analog front end and a single 125 MHz clock.
//
// Behaviour
// RQ1 - Sink active above reference, source below.
// RQ2 - Polarity clear: output high while sink active.
// RQ3 - Polarity set: output inverted, high means source.
// RQ4 - Edges detected after polarity inversion.
// RQ5 - Rising and falling detectors set crossing flag.
// RQ6 - Edge enables gate each detector independently.
// RQ7 - Interrupt needs peripheral, edge and global enables.
// RQ8 - Polarity change edge can set flag regardless.
// RQ9 - Flag stays set until software clears.
// RQ10 - Set wins over simultaneous software clear.
// RQ11 - Polarity-adjusted output offered to other modules.
// RQ12 - Fuse clear forces detector on, ignores enable.
// RQ13 - Logic keeps running unchanged during sleep.
// RQ14 - Control bits 7,5,4,1,0; bits 6,3,2 unused.
// RQ15 - Comparator decision synchronized through two flops.
// RQ16 - Edge pulse compares output with previous value.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module zero_cross_event_logic
    import zc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave.
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Analog front end and configuration fuse.
    input wire logic sink_active,
    input wire logic detector_fuse_n,
    output logic detector_active,
    // Logic output to other modules and interrupt.
    output logic cross_out,
    output logic irq
);

    logic sync1_q;
    logic sync2_q;
    logic out_q;
    logic out_prev_q;
    logic detector_active_q;
    logic fuse_q;
    control_s ctl_q;
    logic [IRQ_WIDTH-1:0] status_q;
    logic [IRQ_WIDTH-1:0] irq_en_q;
    logic [31:0] readdata_q;
    logic ack_q;
    logic irq_q;
    logic out_d;
    logic enabled;
    logic access;
    logic wr_ok;
    edge_s edges;
    logic cross_set;
    logic [IRQ_WIDTH-1:0] clear_mask;
    logic fuse_meta_q;
    logic ctl_wr;
    logic en_wr;
    logic [31:0] read_mux;

    // Fuse strap is a pin: two flops before any logic reads it, never under reset.
    always_ff @(posedge clk)
    begin
        fuse_meta_q <= detector_fuse_n;
        fuse_q <= fuse_meta_q;
    end

    // A cleared fuse keeps the detector on whatever the software enable says.
    assign enabled = !fuse_q || ctl_q.software_detector_enable; // see RQ12

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            detector_active_q <= 1'b0;
        end
        else
        begin
            detector_active_q <= enabled; // see RQ12
        end
    end

    // The front end reports sink while the pin is above the reference; no clock gating,
    // so the chain runs the same in sleep.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sink_active; // see RQ1
        end
    end

    // Only this second stage reads the first one.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync2_q <= 1'b0;
        end
        else
        begin
            sync2_q <= sync1_q; // see RQ15
        end
    end

    // Polarity applied before edge detection.
    assign out_d = sync2_q ^ ctl_q.output_polarity_invert; // see RQ2 see RQ3 see RQ4

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            out_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d; // see RQ13
        end
    end

    // Previous output value; reset matches the idle output so no false edge follows reset.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            out_prev_q <= 1'b0;
        end
        else
        begin
            out_prev_q <= out_q; // see RQ16
        end
    end

    // A polarity write flips out_q and so yields an edge even when disabled.
    assign edges.rise = out_q && !out_prev_q; // see RQ16 see RQ8
    assign edges.fall = !out_q && out_prev_q; // see RQ16
    assign cross_set = (edges.rise && ctl_q.rising_edge_irq_enable)
        || (edges.fall && ctl_q.falling_edge_irq_enable); // see RQ5 see RQ6

    // Bus access: answer one cycle after the request; a write lands at the answer edge.
    assign access = (read || write) && !ack_q;
    assign wr_ok = write && ack_q && byteenable[0];

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= access;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            waitrequest <= 1'b1;
        end
        else
        begin
            waitrequest <= !access;
        end
    end

    assign ctl_wr = wr_ok && address == ADDR_CONTROL;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctl_q.software_detector_enable <= CONTROL_RESET[CTL_SEN_BIT];
        end
        else if (ctl_wr)
        begin
            ctl_q.software_detector_enable <= writedata[CTL_SEN_BIT]; // see RQ14
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctl_q.output_polarity_invert <= CONTROL_RESET[CTL_POL_BIT];
        end
        else if (ctl_wr)
        begin
            ctl_q.output_polarity_invert <= writedata[CTL_POL_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctl_q.rising_edge_irq_enable <= CONTROL_RESET[CTL_RISE_BIT];
        end
        else if (ctl_wr)
        begin
            ctl_q.rising_edge_irq_enable <= writedata[CTL_RISE_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctl_q.falling_edge_irq_enable <= CONTROL_RESET[CTL_FALL_BIT];
        end
        else if (ctl_wr)
        begin
            ctl_q.falling_edge_irq_enable <= writedata[CTL_FALL_BIT];
        end
    end

    assign en_wr = wr_ok && address == ADDR_IRQ_ENABLE;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_en_q[IRQ_CROSS_BIT] <= IRQ_ENABLE_RESET[IRQ_CROSS_BIT];
        end
        else if (en_wr)
        begin
            irq_en_q[IRQ_CROSS_BIT] <= writedata[IRQ_CROSS_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_en_q[IRQ_GLOBAL_BIT] <= IRQ_ENABLE_RESET[IRQ_GLOBAL_BIT];
        end
        else if (en_wr)
        begin
            irq_en_q[IRQ_GLOBAL_BIT] <= writedata[IRQ_GLOBAL_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_en_q[IRQ_GLOBAL_LOW_BIT] <= IRQ_ENABLE_RESET[IRQ_GLOBAL_LOW_BIT];
        end
        else if (en_wr)
        begin
            irq_en_q[IRQ_GLOBAL_LOW_BIT] <= writedata[IRQ_GLOBAL_LOW_BIT];
        end
    end

    always_comb
    begin
        clear_mask = '0;
        if (wr_ok && address == ADDR_IRQ_CLEAR)
        begin
            clear_mask = writedata[IRQ_WIDTH-1:0];
        end
    end

    // Only software clears the flag, and a new edge wins over the clear.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            status_q[IRQ_CROSS_BIT] <= 1'b0;
        end
        else
        begin
            status_q[IRQ_CROSS_BIT] <= cross_set
                || (status_q[IRQ_CROSS_BIT] && !clear_mask[IRQ_CROSS_BIT]); // see RQ9 see RQ10
        end
    end

    // Status bits 1 and 2 have no event behind them and read as zero.
    always_ff @(posedge clk)
    begin
        status_q[IRQ_GLOBAL_BIT] <= 1'b0;
        status_q[IRQ_GLOBAL_LOW_BIT] <= 1'b0;
    end

    // Cross enable, both global enables and a set flag are all needed.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= status_q[IRQ_CROSS_BIT] && irq_en_q[IRQ_CROSS_BIT]
                && irq_en_q[IRQ_GLOBAL_BIT] && irq_en_q[IRQ_GLOBAL_LOW_BIT]; // see RQ7
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            readdata_q <= 32'h0000_0000;
        end
        else if (access && read)
        begin
            readdata_q <= read_mux;
        end
    end

    // Register read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        unique case (address)
            ADDR_CONTROL:
            begin
                read_mux = {24'h00_0000, ctl_q.software_detector_enable, 1'b0, out_q,
                    ctl_q.output_polarity_invert, 2'h0, ctl_q.rising_edge_irq_enable,
                    ctl_q.falling_edge_irq_enable}; // see RQ14
            end
            ADDR_STATUS:
            begin
                read_mux = {29'h0000_0000, status_q};
            end
            ADDR_IRQ_ENABLE:
            begin
                read_mux = {29'h0000_0000, irq_en_q};
            end
            default:
            begin
                read_mux = 32'h0000_0000;
            end
        endcase
    end

    assign readdata = readdata_q;
    assign cross_out = out_q; // see RQ11
    assign irq = irq_q;
    assign detector_active = detector_active_q;

endmodule : zero_cross_event_logic

`default_nettype wire

// ---- shared/zc_pkg.sv ----
// Package for the zero-cross detector logic: register map, field positions, reset values.
// Assumes a 32-bit Avalon-MM slave decoding byte addresses, one register every four bytes.
package zc_pkg;

    // Register byte addresses.
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hC;

    // Control register fields.
    localparam int CTL_SEN_BIT = 7;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_POL_BIT = 4;
    localparam int CTL_RISE_BIT = 1;
    localparam int CTL_FALL_BIT = 0;

    // Status, clear and enable registers share one layout.
    localparam int IRQ_CROSS_BIT = 0;
    localparam int IRQ_GLOBAL_BIT = 1;
    localparam int IRQ_GLOBAL_LOW_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // Reset values.
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [IRQ_WIDTH-1:0] IRQ_ENABLE_RESET = 3'h0;

    // Values held in the control register.
    typedef struct packed {
        logic software_detector_enable;
        logic output_polarity_invert;
        logic rising_edge_irq_enable;
        logic falling_edge_irq_enable;
    } control_s;

    // Event pulses from the edge detectors.
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;

endpackage : zc_pkg

// ---- tb/ac_source.sv ----
// AC source behind the series resistor, seen through the front-end comparator.
// Assumes the bench sets the pin voltage in millivolts.
`timescale 1ns/100ps
`default_nettype none
module ac_source #(
    parameter int REF_MV = 750
) (
    // Pin voltage and comparator decision.
    input var int volt_mv,
    output logic sink_active
);
    assign sink_active = volt_mv > REF_MV;
endmodule : ac_source
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for zero_cross_event_logic over its register bus.
// Assumes the package, source model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench import zc_pkg::*;;
    logic clk, nrst, read, write, waitrequest, detector_fuse_n, detector_active, cross_out, irq;
    logic sink_active;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rd;
    int volt, n_fail, compares;
    zero_cross_event_logic dut (.clk, .nrst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .sink_active, .detector_fuse_n,
        .detector_active, .cross_out, .irq);
    ac_source src (.volt_mv(volt), .sink_active);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        @(posedge clk);
        while (waitrequest)
            @(posedge clk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : acc
    task rchk(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h00);
        chk(rd, e);
    endtask : rchk
    task wrap_up();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (1000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial
    begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'hF;
        volt = 0;
        detector_fuse_n = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(ADDR_CONTROL, 32'(CONTROL_RESET));
        rchk(ADDR_IRQ_ENABLE, 32'(IRQ_ENABLE_RESET));
        rchk(4'h2, 32'h0);
        chk(32'(detector_active), 32'h0);
        acc(1'b1, ADDR_CONTROL, 8'h13);
        repeat (5) @(posedge clk);
        rchk(ADDR_CONTROL, 32'h33);
        rchk(ADDR_STATUS, 32'h1);
        acc(1'b1, ADDR_CONTROL, 8'hFF);
        rchk(ADDR_CONTROL, 32'hB3);
        chk(32'(detector_active), 32'h1);
        rchk(ADDR_STATUS, 32'h1);
        acc(1'b1, ADDR_IRQ_CLEAR, 8'h01);
        rchk(ADDR_STATUS, 32'h0);
        acc(1'b1, ADDR_CONTROL, 8'h92);
        volt <= 1000;
        repeat (6) @(posedge clk);
        rchk(ADDR_CONTROL, 32'h92);
        rchk(ADDR_STATUS, 32'h0);
        volt <= 0;
        repeat (6) @(posedge clk);
        rchk(ADDR_STATUS, 32'h1);
        acc(1'b1, ADDR_IRQ_ENABLE, 8'h07);
        chk(32'(irq), 32'h1);
        acc(1'b1, ADDR_IRQ_ENABLE, 8'h03);
        chk(32'(irq), 32'h0);
        acc(1'b1, ADDR_IRQ_ENABLE, 8'h07);
        byteenable <= 4'h0;
        acc(1'b1, ADDR_IRQ_CLEAR, 8'h01);
        chk(32'(irq), 32'h1);
        byteenable <= 4'hF;
        acc(1'b1, ADDR_IRQ_CLEAR, 8'h01);
        chk(32'(irq), 32'h0);
        acc(1'b1, ADDR_CONTROL, 8'h81);
        repeat (5) @(posedge clk);
        rchk(ADDR_STATUS, 32'h1);
        volt <= 1000;
        repeat (6) @(posedge clk);
        rchk(ADDR_CONTROL, 32'hA1);
        detector_fuse_n <= 1'b0;
        acc(1'b1, ADDR_CONTROL, 8'h00);
        chk(32'(detector_active), 32'h1);
        chk(32'(cross_out), 32'h1);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

// ---- tb/zc_chk.sv ----
// Checker for zero_cross_event_logic, bound to its ports.
// Assumes one clock and one bus request at a time.
`timescale 1ns/100ps
`default_nettype none
module zc_chk
    import zc_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Front end and outputs.
    input wire logic sink_active,
    input wire logic detector_fuse_n,
    input wire logic detector_active,
    input wire logic cross_out,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence clr_s;
        write && !waitrequest && address == ADDR_IRQ_CLEAR && byteenable[0] && writedata[0]
        && $stable(cross_out) && $past(cross_out) == $past(cross_out, 2);
    endsequence
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer");
    a_answer_short: assert property (!waitrequest |=> waitrequest)
        else $error("long answer");
    a_idle_wait: assert property (!read && !write |=> waitrequest)
        else $error("idle answer");
    a_unmapped_zero: assert property (read && !waitrequest && address == 4'h2 |-> readdata == 32'h0)
        else $error("unmapped data");
    a_fuse_on: assert property (!detector_fuse_n ##1 !detector_fuse_n ##1 !detector_fuse_n
        |=> detector_active)
        else $error("fuse ignored");
    a_sync_delay: assert property ($changed(sink_active) && !write ##1 !write [*3]
        |-> $changed(cross_out)) else $error("output latency");
    a_irq_cause: assert property ($rose(irq) && !$past(write) && !$past(write, 2)
        |-> $past(cross_out, 2) != $past(cross_out, 3)) else $error("stray irq");
    a_clear_drops: assert property (clr_s ##1 $stable(cross_out) |=> !irq)
        else $error("clear lost");
endmodule : zc_chk
bind zero_cross_event_logic zc_chk u_chk (.clk, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .sink_active, .detector_fuse_n, .detector_active,
    .cross_out, .irq);
`default_nettype wire
